// >>> hw/sfc_axis_comp.sv
// Axis backlash compensation, parallel TTL feedback port and reference position latch, APB slave.
// Assumes all inputs synchronous to clk and update_tick a one-cycle pulse per servo update.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.svh"

// Notes on behaviour
// (RL1) Reversal adds or subtracts backlash from command.
// (RL2) Correction after command; actual includes it.
// (RL3) Direction assumed positive after reset.
// (RL4) Software winds up slack before writing backlash.
// (RL5) Backlash at index 27, 0..32767, reset 0.
// (RL6) TTL read returns 24 inputs, low bits.
// (RL7) Data-valid mode: waiting flag in MSB.
// (RL8) Loop close succeeds only with flag high.
// (RL9) Software waits for flag before loop close.
// (RL10) TTL write drives eight outputs from LSBs.
// (RL11) Encoder: switch to index distance captured.
// (RL12) Resolver: absolute position at switch closure.
// (RL13) Analog or TTL: absolute position when referencing.
// (RL14) Reference counts fixed direction, ignoring polarity.
// (RL15) Capture within eight updates, one if fast.
// (RL16) Stepper axis: these functions report unsupported.
// (RL17) Fast queuing: events within one interrupt.
// (RL18) Direction from sign of change; zero keeps.
module sfc_axis_comp #(
  parameter bit STEPPER_AXIS = 1'b0,
  parameter int SLOW_POLL = `SFC_SLOW_POLL
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic update_tick,
  input wire logic signed [31:0] cmd_pos,
  output logic signed [31:0] drive_pos,
  input wire logic [`SFC_TTL_IN_W-1:0] ttl_in,
  output logic [`SFC_TTL_OUT_W-1:0] ttl_out,
  input wire logic signed [31:0] fb_pos,
  input wire logic ref_switch,
  input wire logic index_mark,
  input wire logic loop_close_request,
  output logic loop_close_ok,
  output logic queue_poll,
  output logic irq
);

  localparam logic [2:0] POLL_LAST = 3'(SLOW_POLL - 1);
  localparam bit HAS_FEAT = !STEPPER_AXIS;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, access completes on the pready edge.
  sfc_pkg::sfc_apb_req_t req;
  logic [7:0] idx;
  logic done;
  logic wr;
  logic rd;
  logic next_err;
  logic [31:0] next_rdata;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign idx = req.paddr[9:2];
  assign done = req.psel && req.penable && pready;
  assign wr = done && req.pwrite && !pslverr;
  assign rd = done && !req.pwrite;
  logic fastq;
  logic [14:0] backlash;
  sfc_pkg::sfc_cfg_t cfg;
  logic [`SFC_EV_W-1:0] status;
  logic [`SFC_EV_W-1:0] mask;
  logic wait_flag;
  logic signed [31:0] refpos;
  logic signed [31:0] offset;
  sfc_pkg::sfc_ref_state_t ref_state;
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (idx)
      `SFC_IDX_ACTUAL: next_rdata = drive_pos;
      `SFC_IDX_CMD: next_rdata = cmd_pos;
      `SFC_IDX_FASTQ: next_rdata = {31'h00000000, fastq};
      `SFC_IDX_BACKLASH:
      begin
        next_rdata = {17'h00000, backlash};
        next_err = !HAS_FEAT || (req.pwrite && req.pwdata > `SFC_BACKLASH_MAX); // RL5 RL16
      end
      `SFC_IDX_TTL:
      begin
        next_rdata = {cfg.valid_en && wait_flag, 7'h00, ttl_in}; // RL6 RL7
        next_err = !HAS_FEAT; // RL16
      end
      `SFC_IDX_REFPOS:
      begin
        next_rdata = refpos;
        next_err = !HAS_FEAT || req.pwrite; // RL16
      end
      `SFC_IDX_CONFIG: next_rdata = {28'h0000000, cfg, ref_state != sfc_pkg::SFC_REF_IDLE};
      `SFC_IDX_STATUS: next_rdata = {29'h00000000, status};
      `SFC_IDX_MASK: next_rdata = {29'h00000000, mask};
      default: next_err = 1'b1;
    endcase
    if (!HAS_FEAT || next_err)
      next_rdata = 32'h00000000;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= req.psel && req.penable && !pready;
      pslverr <= req.psel && req.penable && !pready && next_err;
      if (req.psel && req.penable && !pready)
        prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fastq <= 1'b0;
      backlash <= `SFC_BACKLASH_RST;
      cfg <= '{valid_en: 1'b0, fb_type: sfc_pkg::SFC_FB_ENCODER};
      mask <= '0;
      ttl_out <= '0;
    end
    else if (wr)
    begin
      case (idx)
        `SFC_IDX_FASTQ: fastq <= req.pwdata[0];
        `SFC_IDX_BACKLASH: backlash <= req.pwdata[14:0]; // RL5
        `SFC_IDX_TTL: ttl_out <= req.pwdata[`SFC_TTL_OUT_W-1:0]; // RL10
        `SFC_IDX_CONFIG:
        begin
          cfg.valid_en <= req.pwdata[`SFC_CFG_VALID_EN];
          cfg.fb_type <= sfc_pkg::sfc_fb_t'(req.pwdata[`SFC_CFG_FB_LO+1:`SFC_CFG_FB_LO]);
        end
        `SFC_IDX_MASK: mask <= req.pwdata[`SFC_EV_W-1:0];
        default: mask <= mask;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Backlash compensation on the servo update.
  logic signed [31:0] prev_cmd;
  logic signed [31:0] delta;
  logic dir_pos;
  logic rev_neg;
  logic rev_pos;
  assign delta = cmd_pos - prev_cmd;
  assign rev_neg = update_tick && dir_pos && delta < 0; // RL18
  assign rev_pos = update_tick && !dir_pos && delta > 0; // RL18
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prev_cmd <= 32'h00000000;
      dir_pos <= 1'b1; // RL3
      offset <= 32'h00000000;
      drive_pos <= 32'h00000000;
    end
    else
    begin
      drive_pos <= cmd_pos + offset; // RL2
      if (update_tick)
        prev_cmd <= cmd_pos;
      if (rev_neg && HAS_FEAT)
      begin
        dir_pos <= 1'b0;
        offset <= offset - 32'(backlash); // RL1
      end
      else if (rev_pos && HAS_FEAT)
      begin
        dir_pos <= 1'b1;
        offset <= offset + 32'(backlash); // RL1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event polling: every update with fast queuing, else every eighth.
  logic [2:0] pcnt;
  logic poll;
  assign poll = update_tick && (fastq || pcnt == POLL_LAST); // RL15 RL17
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pcnt <= 3'h0;
      queue_poll <= 1'b0;
    end
    else
    begin
      queue_poll <= poll; // RL17
      if (update_tick)
        pcnt <= (pcnt == POLL_LAST) ? 3'h0 : pcnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference position latch; raw feedback is used so polarity setup has no effect.
  logic signed [31:0] ref_start;
  logic arm;
  logic ref_ev;
  assign arm = wr && idx == `SFC_IDX_CONFIG && req.pwdata[`SFC_CFG_ARM] && HAS_FEAT;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ref_state <= sfc_pkg::SFC_REF_IDLE;
      ref_start <= 32'h00000000;
      refpos <= 32'h00000000;
      ref_ev <= 1'b0;
    end
    else
    begin
      ref_ev <= 1'b0;
      case (ref_state)
        sfc_pkg::SFC_REF_IDLE:
        begin
          if (arm)
            ref_state <= sfc_pkg::SFC_REF_ARMED;
        end
        sfc_pkg::SFC_REF_ARMED:
        begin
          if (poll && ref_switch)
          begin
            if (cfg.fb_type == sfc_pkg::SFC_FB_ENCODER)
            begin
              ref_start <= fb_pos; // RL11
              ref_state <= sfc_pkg::SFC_REF_INDEX;
            end
            else
            begin
              refpos <= fb_pos; // RL12 RL13 RL14
              ref_ev <= 1'b1;
              ref_state <= sfc_pkg::SFC_REF_IDLE;
            end
          end
        end
        sfc_pkg::SFC_REF_INDEX:
        begin
          if (index_mark)
          begin
            refpos <= fb_pos - ref_start; // RL11 RL14
            ref_ev <= 1'b1;
            ref_state <= sfc_pkg::SFC_REF_IDLE;
          end
        end
        default: ref_state <= sfc_pkg::SFC_REF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // TTL valid flag and loop closing.
  logic valid_rise;
  assign valid_rise = cfg.valid_en && ttl_in[`SFC_TTL_IN_W-1] && !wait_flag;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wait_flag <= 1'b0;
      loop_close_ok <= 1'b0;
    end
    else
    begin
      if (!cfg.valid_en)
        wait_flag <= 1'b0;
      else if (valid_rise)
        wait_flag <= 1'b1; // RL7
      loop_close_ok <= loop_close_request && HAS_FEAT && (!cfg.valid_en || wait_flag); // RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, cleared by its read; a new event wins over the clear.
  logic [`SFC_EV_W-1:0] ev;
  logic st_clr;
  assign ev = {rev_neg || rev_pos, valid_rise, ref_ev};
  assign st_clr = rd && idx == `SFC_IDX_STATUS;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status <= (st_clr ? '0 : status) | ev;
      irq <= |(((st_clr ? '0 : status) | ev) & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Updates since the last event poll; bounds how late a reference capture can be.
  logic [3:0] tick_gap;
  always_ff @(posedge clk)
  begin
    if (!reset_n || poll)
      tick_gap <= 4'h0;
    else if (update_tick)
      tick_gap <= tick_gap + 4'h1;
  end
  sequence s_rev_neg;
    rev_neg && HAS_FEAT;
  endsequence
  property p_rev_neg;
    @(posedge clk) disable iff (!reset_n) s_rev_neg |=> offset == $past(offset) - 32'($past(backlash));
  endproperty
  a_rev_neg: assert property (p_rev_neg) else $error("offset not reduced on reversal"); // RL1
  property p_actual;
    @(posedge clk) disable iff (!reset_n) 1'b1 |=> drive_pos == $past(cmd_pos) + $past(offset);
  endproperty
  a_actual: assert property (p_actual) else $error("actual position misses correction"); // RL2
  property p_zero_keep;
    @(posedge clk) disable iff (!reset_n) update_tick && delta == 0 |=> dir_pos == $past(dir_pos);
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero change flipped direction"); // RL18
  property p_bl_range;
    @(posedge clk) disable iff (!reset_n) wr && idx == `SFC_IDX_BACKLASH |=> backlash == $past(req.pwdata[14:0]);
  endproperty
  a_bl_range: assert property (p_bl_range) else $error("backlash write lost"); // RL5
  property p_ttl_out;
    @(posedge clk) disable iff (!reset_n) wr && idx == `SFC_IDX_TTL |=> ttl_out == $past(req.pwdata[7:0]);
  endproperty
  a_ttl_out: assert property (p_ttl_out) else $error("ttl outputs not driven"); // RL10
  property p_loop_ok;
    @(posedge clk) disable iff (!reset_n) loop_close_ok |-> !$past(cfg.valid_en) || $past(wait_flag);
  endproperty
  a_loop_ok: assert property (p_loop_ok) else $error("loop closed while waiting"); // RL8
  property p_slow_poll;
    @(posedge clk) disable iff (!reset_n) update_tick |-> tick_gap < 4'(SLOW_POLL);
  endproperty
  a_slow_poll: assert property (p_slow_poll) else $error("slow poll off cadence"); // RL15
  property p_fast_poll;
    @(posedge clk) disable iff (!reset_n) update_tick && fastq |=> queue_poll;
  endproperty
  a_fast_poll: assert property (p_fast_poll) else $error("fast poll missed update"); // RL17
  property p_irq;
    @(posedge clk) disable iff (!reset_n) 1'b1 |=> irq == |(status & $past(mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not tied to status"); // RL1
  property p_stepper;
    @(posedge clk) disable iff (!reset_n) !HAS_FEAT |-> offset == 32'h00000000 && !loop_close_ok;
  endproperty
  a_stepper: assert property (p_stepper) else $error("stepper axis applies features"); // RL16

endmodule
`default_nettype wire

// >>> hw/sfc_defines.svh
// Register indices, field positions, reset values and timing counts for the axis block.
// Assumes byte address equals four times the register index on APB.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
`define SFC_IDX_ACTUAL 8'h01
`define SFC_IDX_CMD 8'h03
`define SFC_IDX_FASTQ 8'h19
`define SFC_IDX_BACKLASH 8'h1B
`define SFC_IDX_TTL 8'h1C
`define SFC_IDX_REFPOS 8'h1D
`define SFC_IDX_CONFIG 8'h28
`define SFC_IDX_STATUS 8'h29
`define SFC_IDX_MASK 8'h2A
`define SFC_BACKLASH_MAX 32'h00007FFF
`define SFC_BACKLASH_RST 15'h0000
`define SFC_TTL_IN_W 24
`define SFC_TTL_OUT_W 8
`define SFC_CFG_ARM 0
`define SFC_CFG_FB_LO 1
`define SFC_CFG_VALID_EN 3
`define SFC_EV_REF 0
`define SFC_EV_VALID 1
`define SFC_EV_REV 2
`define SFC_EV_W 3
`define SFC_SLOW_POLL 8
`endif

// >>> hw/sfc_pkg.sv
// Types shared by the axis feedback and compensation block.
// Assumes sfc_defines.svh is on the include path.
package sfc_pkg;
  typedef enum logic [1:0] {SFC_FB_ENCODER, SFC_FB_RESOLVER, SFC_FB_ANALOG, SFC_FB_TTL} sfc_fb_t;
  typedef enum logic [1:0] {SFC_REF_IDLE, SFC_REF_ARMED, SFC_REF_INDEX} sfc_ref_state_t;
  typedef struct packed {
    logic valid_en;
    sfc_fb_t fb_type;
  } sfc_cfg_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sfc_apb_req_t;
endpackage

// >>> sim/sfc_fb_model.sv
// Model of the feedback hardware: TTL inputs, position feedback, home switch and index mark.
// Assumes the bench calls its tasks from one process that runs in step with clk.
`timescale 1ns/100ps
`default_nettype none
module sfc_fb_model (
  input wire logic clk,
  output logic [23:0] ttl_in,
  output logic signed [31:0] fb_pos,
  output logic ref_switch,
  output logic index_mark
);
  initial
  begin
    ttl_in = 24'h000000;
    fb_pos = 32'sh0;
    ref_switch = 1'b0;
    index_mark = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Data settle one cycle before the valid flag, as real hardware would present them.
  task automatic send(input logic [22:0] d, input logic v);
    @(posedge clk);
    ttl_in <= {1'b0, d};
    @(posedge clk);
    ttl_in[23] <= v;
    repeat (2) @(posedge clk);
  endtask
  task automatic sw(input logic signed [31:0] p);
    @(posedge clk);
    fb_pos <= p;
    ref_switch <= 1'b1;
  endtask
  // The switch is released with the index so no later poll can capture again.
  task automatic index(input logic signed [31:0] p);
    @(posedge clk);
    fb_pos <= p;
    index_mark <= 1'b1;
    @(posedge clk);
    index_mark <= 1'b0;
    ref_switch <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/sfc_axis_comp_tb.sv
// Self-checking bench for the axis block: APB master, servo ticks and a reference model.
// Assumes sfc_fb_model stands at the feedback pins and sfc_defines.svh is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.svh"
module sfc_axis_comp_tb;
  localparam int POLL = 2;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, update_tick, ref_switch, index_mark;
  logic loop_close_request, loop_close_ok, queue_poll, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic signed [31:0] cmd_pos, drive_pos, fb_pos, prev;
  logic [23:0] ttl_in;
  logic [7:0] ttl_out;
  int error_cnt, total_checks, bl, off, polls, pend, msk;
  bit dir_pos;
  int cmds[6] = '{150, 120, 120, 110, 130, 100};
  logic [31:0] cfgs[4] = '{32'h3, 32'h1, 32'h7, 32'h5};
  int swp[4] = '{5000, 7000, -42, 900};
  int exps[4] = '{5000, 350, -42, 900};
  sfc_axis_comp #(.STEPPER_AXIS(1'b0), .SLOW_POLL(POLL)) i_sfc_axis_comp (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .update_tick(update_tick), .cmd_pos(cmd_pos), .drive_pos(drive_pos),
    .ttl_in(ttl_in), .ttl_out(ttl_out), .fb_pos(fb_pos), .ref_switch(ref_switch), .index_mark(index_mark),
    .loop_close_request(loop_close_request), .loop_close_ok(loop_close_ok), .queue_poll(queue_poll), .irq(irq));
  sfc_fb_model i_sfc_fb_model (.clk(clk), .ttl_in(ttl_in), .fb_pos(fb_pos), .ref_switch(ref_switch),
    .index_mark(index_mark));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (queue_poll === 1'b1)
      polls++;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // The master waits on pready with no assumed latency; the bound only catches a hang.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!w && idx == `SFC_IDX_STATUS)
      pend = 0;
    if (n == 20)
      chk("pready", 1'b0, 1'b1);
  endtask
  task automatic tick(input logic signed [31:0] c);
    @(posedge clk);
    cmd_pos <= c;
    update_tick <= 1'b1;
    @(posedge clk);
    update_tick <= 1'b0;
    if (c < prev && dir_pos)
    begin
      off -= bl;
      dir_pos = 1'b0;
      pend |= 4;
    end
    else if (c > prev && !dir_pos)
    begin
      off += bl;
      dir_pos = 1'b1;
      pend |= 4;
    end
    prev = c;
    repeat (3) @(posedge clk);
    chk("drive_pos", drive_pos, c + off);
    chk("irq", irq, (pend & msk) != 0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    {reset_n, psel, penable, pwrite, update_tick, loop_close_request} = 6'h00;
    {paddr, pwdata, cmd_pos, prev, rnd} = {12'h000, 32'h0, 32'h0, 32'h0, 32'h00000018};
    {error_cnt, total_checks, bl, off, polls, pend, msk} = '0;
    dir_pos = 1'b1;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    apb(0, `SFC_IDX_BACKLASH, 0);
    chk("backlash_rst", rd, 0);
    chk("ttl_out_rst", ttl_out, 0);
    $display("test reset done");
    tick(32'sd100);
    apb(1, `SFC_IDX_BACKLASH, 32'h8000);
    chk("bl_range", err, 1'b1);
    apb(1, `SFC_IDX_BACKLASH, 32'h7FFF);
    apb(0, `SFC_IDX_BACKLASH, 0);
    chk("bl_max", rd, 32'h7FFF);
    bl = 200;
    apb(1, `SFC_IDX_BACKLASH, bl);
    msk = 4;
    apb(1, `SFC_IDX_MASK, msk);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5)
      begin
        apb(0, `SFC_IDX_STATUS, 0);
        msk = 0;
        apb(1, `SFC_IDX_MASK, msk);
      end
      tick(cmds[i]);
    end
    apb(0, `SFC_IDX_CMD, 0);
    chk("cmd_rd", rd, 32'd100);
    apb(0, `SFC_IDX_ACTUAL, 0);
    chk("act_rd", rd, 100 + off);
    $display("test backlash done");
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      i_sfc_fb_model.send(rnd[22:0], rnd[23]);
      apb(0, `SFC_IDX_TTL, 0);
      chk("ttl_rd", rd, {8'h00, ttl_in});
      apb(1, `SFC_IDX_TTL, rnd);
      @(posedge clk);
      chk("ttl_out", ttl_out, rnd[7:0]);
    end
    i_sfc_fb_model.send(23'h00ABCD, 1'b0);
    apb(1, `SFC_IDX_CONFIG, 32'h8);
    apb(0, `SFC_IDX_TTL, 0);
    chk("wait_lo", rd, {8'h00, ttl_in});
    loop_close(1'b0);
    i_sfc_fb_model.send(23'h00ABCD, 1'b1);
    apb(0, `SFC_IDX_TTL, 0);
    chk("wait_hi", rd, {8'h80, ttl_in});
    loop_close(1'b1);
    $display("test ttl done");
    for (int m = 0; m < 4; m++)
    begin
      apb(1, `SFC_IDX_CONFIG, cfgs[m]);
      i_sfc_fb_model.sw(swp[m]);
      repeat (4) tick(prev);
      i_sfc_fb_model.index(swp[m] + 350);
      repeat (2) @(posedge clk);
      apb(0, `SFC_IDX_STATUS, 0);
      chk("ref_done", rd[0], 1'b1);
      apb(0, `SFC_IDX_REFPOS, 0);
      chk("ref_pos", rd, exps[m]);
    end
    apb(1, `SFC_IDX_REFPOS, 1);
    chk("ref_ro", err, 1'b1);
    apb(0, 8'h3F, 0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h00000000);
    $display("test reference done");
    polls = 0;
    repeat (4) tick(prev);
    chk("poll_slow", polls, 4 / POLL);
    apb(1, `SFC_IDX_FASTQ, 1);
    polls = 0;
    repeat (4) tick(prev);
    chk("poll_fast", polls, 4);
    $display("test queuing done");
    finish_test();
  end
  task automatic loop_close(input logic exp);
    @(posedge clk);
    loop_close_request <= 1'b1;
    @(posedge clk);
    loop_close_request <= 1'b0;
    @(posedge clk);
    chk("loop_ok", loop_close_ok, exp);
  endtask
endmodule
`default_nettype wire
